// ### hw/ucd_top.sv
// Charger detection registers, linestate reporting and ID conversion.
// ==========================================================
// What this block does
// - In synchronous mode session valid is reported in the receive command.
// - In non-synchronous modes the interrupt is driven on data line 3.
// - Writing 49h to function control selects non-driving full-speed mode.
// - Bit 4 of IO power register connects the DP charger pull-up.
// - Sync mode shows linestate in receive command and debug register.
// - Non-synchronous modes drive linestate onto data lines 0 and 1.
// - Bit 5 enables DM pull-up; UART mode enables it automatically.
`timescale 1ns/1ps

module ucd_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparators and pins
  input wire ucd_pkg::ucd_pins_s pins_in,
  // Interface mode from link-side logic
  input wire ucd_pkg::ucd_mode_e ulpi_mode,
  // Data bus towards the link
  output logic [7:0] ulpi_dout,
  output logic ulpi_doe,
  output logic rxcmd_valid,
  // Analog controls
  output logic charger_dp_pullup_enable,
  output logic charger_dm_pullup_enable,
  output logic id_pin_pullup_enable,
  output logic [1:0] xcvr_select,
  output logic term_select,
  output logic [1:0] op_mode,
  output logic suspend_n,
  // Interrupt
  output logic irq
);
  import ucd_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // The filtered value sets when stages two and three are both high, clears when they differ and holds when both are low.
  localparam int PW = $bits(ucd_pins_s);
  logic [PW-1:0] sync1;
  logic [PW-1:0] sync2;
  logic [PW-1:0] sync3;
  logic [PW-1:0] filt;
  logic [PW-1:0] next_filt;
  ucd_pins_s pf;

  always_comb begin
    next_filt = (sync2 & sync3) | (filt & ~(sync2 ^ sync3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end else begin
      sync1 <= pins_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  assign pf = ucd_pins_s'(filt);

  // ==========================================================
  // Linestate and change detection
  logic [1:0] line_level;
  logic [1:0] prev_ls;
  logic prev_sess;
  logic prev_id_grounded_flag;
  logic ls_chg;
  logic sess_chg;
  logic id_grounded_flag_chg;

  assign line_level = {pf.dm_level, pf.dp_level};
  assign ls_chg = (line_level != prev_ls);
  assign sess_chg = (pf.session_valid != prev_sess);
  assign id_grounded_flag_chg = (pf.id_grounded != prev_id_grounded_flag);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ls <= 2'h0;
      prev_sess <= 1'b0;
      prev_id_grounded_flag <= 1'b0;
    end else begin
      prev_ls <= line_level;
      prev_sess <= pf.session_valid;
      prev_id_grounded_flag <= pf.id_grounded;
    end
  end

  // ==========================================================
  // APB decode
  logic acc;
  logic wr;
  logic [9:0] idx;
  logic mapped;

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign idx = paddr[11:2];

  always_comb begin
    mapped = (paddr[1:0] == 2'h0) &&
             (idx == UCD_FUNC_CTRL_IDX || idx == UCD_IO_PWR_IDX ||
              idx == UCD_DEBUG_IDX || idx == UCD_STATUS_IDX ||
              idx == UCD_CTRL_IDX || idx == UCD_IRQ_STAT_IDX ||
              idx == UCD_IRQ_MASK_IDX);
  end

  // ==========================================================
  // Registers and ID conversion
  logic [7:0] func_ctrl;
  logic [7:0] io_pwr;
  logic idpu;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  ucd_conv_e conv_st;
  logic [7:0] conv_cnt;
  logic conv_done;
  logic [2:0] rid_result;
  logic [7:0] next_func_ctrl;
  logic [7:0] next_io_pwr;
  logic next_idpu;
  logic [3:0] next_irq_stat;
  logic [3:0] next_irq_mask;
  ucd_conv_e next_conv_st;
  logic [7:0] next_conv_cnt;
  logic next_conv_done;
  logic [2:0] next_rid_result;
  logic conv_end;
  logic [3:0] ev;

  always_comb begin
    next_func_ctrl = func_ctrl;
    next_io_pwr = io_pwr;
    next_idpu = idpu;
    next_irq_mask = irq_mask;
    next_conv_st = conv_st;
    next_conv_cnt = conv_cnt;
    next_conv_done = conv_done;
    next_rid_result = rid_result;
    conv_end = 1'b0;
    if (wr && idx == UCD_FUNC_CTRL_IDX) begin
      next_func_ctrl = pwdata[7:0];
    end
    if (wr && idx == UCD_IO_PWR_IDX) begin
      next_io_pwr = pwdata[7:0];
    end
    if (wr && idx == UCD_IRQ_MASK_IDX) begin
      next_irq_mask = pwdata[3:0];
    end
    if (wr && idx == UCD_CTRL_IDX) begin
      next_idpu = pwdata[UCD_CTRL_IDPU_BIT];
    end
    case (conv_st)
      UCD_CONV_IDLE: begin
        if (wr && idx == UCD_CTRL_IDX && pwdata[UCD_CTRL_GO_BIT]) begin
          next_conv_st = UCD_CONV_BUSY;
          next_conv_cnt = 8'(UCD_RID_CONV_CYC - 1);
          next_conv_done = 1'b0;
        end
      end
      UCD_CONV_BUSY: begin
        if (conv_cnt == 8'h00) begin
          next_conv_st = UCD_CONV_IDLE;
          next_conv_done = 1'b1;
          next_rid_result = pf.id_resistance;
          conv_end = 1'b1;
        end else begin
          next_conv_cnt = conv_cnt - 8'h01;
        end
      end
      default: begin
        next_conv_st = UCD_CONV_IDLE;
      end
    endcase
    ev = 4'h0;
    ev[UCD_IRQ_SESS_BIT] = sess_chg;
    ev[UCD_IRQ_ID_GROUNDED_FLAG_BIT] = id_grounded_flag_chg;
    ev[UCD_IRQ_CONV_BIT] = conv_end;
    ev[UCD_IRQ_LS_BIT] = ls_chg;
    // A new event wins over a write-one clear in the same cycle.
    next_irq_stat = irq_stat;
    if (wr && idx == UCD_IRQ_STAT_IDX) begin
      next_irq_stat = irq_stat & ~pwdata[3:0];
    end
    next_irq_stat = next_irq_stat | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_ctrl <= UCD_FUNC_CTRL_RST;
      io_pwr <= UCD_IO_PWR_RST;
      idpu <= 1'b0;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      conv_st <= UCD_CONV_IDLE;
      conv_cnt <= 8'h00;
      conv_done <= 1'b0;
      rid_result <= 3'h0;
    end else begin
      func_ctrl <= next_func_ctrl;
      io_pwr <= next_io_pwr;
      idpu <= next_idpu;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      conv_st <= next_conv_st;
      conv_cnt <= next_conv_cnt;
      conv_done <= next_conv_done;
      rid_result <= next_rid_result;
    end
  end

  // ==========================================================
  // APB answer and read mux
  // Answering one cycle after setup keeps every access at two cycles.
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [7:0] rd;

  always_comb begin
    rd = 8'h00;
    case (idx)
      UCD_FUNC_CTRL_IDX: rd = func_ctrl;
      UCD_IO_PWR_IDX: rd = io_pwr;
      UCD_DEBUG_IDX: rd = {6'h00, line_level};
      UCD_STATUS_IDX: rd = {line_level, rid_result, conv_done,
                            pf.id_grounded, pf.session_valid};
      UCD_CTRL_IDX: rd = {6'h00, (conv_st == UCD_CONV_BUSY), idpu};
      UCD_IRQ_STAT_IDX: rd = {4'h0, irq_stat};
      UCD_IRQ_MASK_IDX: rd = {4'h0, irq_mask};
      default: rd = 8'h00;
    endcase
    next_pready = psel & ~penable;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_prdata = pwrite ? 32'h0 : {24'h0, rd};
      next_pslverr = ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Link data bus, analog controls and interrupt
  logic irq_any;
  logic in_uart;
  logic rx_evt;
  logic [7:0] next_dout;
  logic next_doe;
  logic next_rxv;

  assign irq_any = |(irq_stat & irq_mask);
  assign in_uart = (ulpi_mode == UCD_MODE_UART);
  assign rx_evt = ls_chg | sess_chg;

  always_comb begin
    next_dout = 8'h00;
    next_doe = 1'b0;
    next_rxv = 1'b0;
    if (ulpi_mode == UCD_MODE_SYNC) begin
      if (rx_evt) begin
        next_rxv = 1'b1;
        next_doe = 1'b1;
        next_dout = {1'b0, pf.id_grounded, 2'h0,
                     pf.session_valid, 1'b0, line_level};
      end
    end else begin
      next_doe = 1'b1;
      next_dout[1:0] = line_level;
      next_dout[UCD_DATA_INT_BIT] = irq_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ulpi_dout <= 8'h00;
      ulpi_doe <= 1'b0;
      rxcmd_valid <= 1'b0;
      charger_dp_pullup_enable <= 1'b0;
      charger_dm_pullup_enable <= 1'b0;
      id_pin_pullup_enable <= 1'b0;
      xcvr_select <= 2'h0;
      term_select <= 1'b0;
      op_mode <= 2'h0;
      suspend_n <= 1'b0;
      irq <= 1'b0;
    end else begin
      ulpi_dout <= next_dout;
      ulpi_doe <= next_doe;
      rxcmd_valid <= next_rxv;
      charger_dp_pullup_enable <= io_pwr[UCD_IO_DP_PU_BIT] | in_uart;
      charger_dm_pullup_enable <= io_pwr[UCD_IO_DM_PU_BIT] | in_uart;
      id_pin_pullup_enable <= idpu;
      xcvr_select <= func_ctrl[1:0];
      term_select <= func_ctrl[2];
      op_mode <= func_ctrl[4:3];
      suspend_n <= func_ctrl[6];
      irq <= irq_any;
    end
  end

endmodule

// ### shared/ucd_pkg.sv
// Shared constants and types for the charger detection register block.
package ucd_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index.
  localparam logic [9:0] UCD_FUNC_CTRL_IDX = 10'h004;
  localparam logic [9:0] UCD_IO_PWR_IDX = 10'h03a;
  localparam logic [9:0] UCD_DEBUG_IDX = 10'h015;
  localparam logic [9:0] UCD_STATUS_IDX = 10'h040;
  localparam logic [9:0] UCD_CTRL_IDX = 10'h041;
  localparam logic [9:0] UCD_IRQ_STAT_IDX = 10'h042;
  localparam logic [9:0] UCD_IRQ_MASK_IDX = 10'h043;

  // ==========================================================
  // Reset values and the full-speed non-driving setting.
  localparam logic [7:0] UCD_FUNC_CTRL_RST = 8'h41;
  localparam logic [7:0] UCD_IO_PWR_RST = 8'h04;
  localparam logic [7:0] UCD_FS_NONDRIVE_VAL = 8'h49;

  // ==========================================================
  // Field positions.
  localparam int UCD_IO_DP_PU_BIT = 4;
  localparam int UCD_IO_DM_PU_BIT = 5;
  localparam int UCD_CTRL_IDPU_BIT = 0;
  localparam int UCD_CTRL_GO_BIT = 1;
  localparam int UCD_IRQ_SESS_BIT = 0;
  localparam int UCD_IRQ_ID_GROUNDED_FLAG_BIT = 1;
  localparam int UCD_IRQ_CONV_BIT = 2;
  localparam int UCD_IRQ_LS_BIT = 3;
  localparam int UCD_DATA_INT_BIT = 3;

  // ==========================================================
  // Timing.
  localparam int UCD_CLK_NS = 20;
  localparam int UCD_RID_CONV_NS = 1000;
  localparam int UCD_RID_CONV_CYC =
    (UCD_RID_CONV_NS + UCD_CLK_NS - 1) / UCD_CLK_NS;

  // ==========================================================
  // Types.
  typedef enum logic [1:0] {
    UCD_MODE_SYNC = 2'b00,
    UCD_MODE_LOWPOWER = 2'b01,
    UCD_MODE_SERIAL = 2'b10,
    UCD_MODE_UART = 2'b11
  } ucd_mode_e;

  typedef enum logic {
    UCD_CONV_IDLE = 1'b0,
    UCD_CONV_BUSY = 1'b1
  } ucd_conv_e;

  typedef struct packed {
    logic [2:0] id_resistance;
    logic session_valid;
    logic id_grounded;
    logic dm_level;
    logic dp_level;
  } ucd_pins_s;

endpackage

// ### tb/ucd_checker.sv
// Assertion checker for the charger detection register block.
`timescale 1ns/1ps
module ucd_checker (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Link side
  input wire ucd_pkg::ucd_mode_e ulpi_mode,
  input wire logic [7:0] ulpi_dout,
  input wire logic ulpi_doe,
  input wire logic rxcmd_valid,
  // Analog controls
  input wire logic charger_dp_pullup_enable,
  input wire logic charger_dm_pullup_enable,
  input wire logic [1:0] xcvr_select,
  input wire logic term_select,
  input wire logic [1:0] op_mode,
  input wire logic suspend_n
);
  import ucd_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  // ==========================================================
  // Properties
  property p_ready_one;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("pready not one cycle");
  property p_func49;
    wr && paddr == 12'h010 && pwdata[7:0] == 8'h49 |-> ##2
      xcvr_select == 2'b01 && !term_select && op_mode == 2'b01 && suspend_n;
  endproperty
  a_func49: assert property (p_func49)
    else $error("bad full-speed setup");
  property p_dp_pu;
    wr && paddr == 12'h0e8 && pwdata[4] |-> ##2 charger_dp_pullup_enable;
  endproperty
  a_dp_pu: assert property (p_dp_pu)
    else $error("dp pull-up off");
  property p_dm_pu;
    wr && paddr == 12'h0e8 && pwdata[5] |-> ##2 charger_dm_pullup_enable;
  endproperty
  a_dm_pu: assert property (p_dm_pu)
    else $error("dm pull-up off");
  property p_uart;
    ulpi_mode == UCD_MODE_UART [*2] |->
      charger_dp_pullup_enable && charger_dm_pullup_enable;
  endproperty
  a_uart: assert property (p_uart)
    else $error("uart pull-ups off");
  property p_nonsync;
    ulpi_mode != UCD_MODE_SYNC [*2] |->
      ulpi_doe && ulpi_dout[7:4] == 4'h0 && !ulpi_dout[2];
  endproperty
  a_nonsync: assert property (p_nonsync)
    else $error("bad non-sync bus");
  property p_rxcmd;
    rxcmd_valid |-> ulpi_doe && $past(ulpi_mode) == UCD_MODE_SYNC &&
      !ulpi_dout[7] && ulpi_dout[5:4] == 2'h0 && !ulpi_dout[2];
  endproperty
  a_rxcmd: assert property (p_rxcmd)
    else $error("bad receive command");
  property p_sync_idle;
    ulpi_mode == UCD_MODE_SYNC [*2] ##0 !rxcmd_valid |-> !ulpi_doe;
  endproperty
  a_sync_idle: assert property (p_sync_idle)
    else $error("bus driven when idle");
endmodule
bind ucd_top ucd_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .ulpi_mode(ulpi_mode),
  .ulpi_dout(ulpi_dout), .ulpi_doe(ulpi_doe), .rxcmd_valid(rxcmd_valid),
  .charger_dp_pullup_enable(charger_dp_pullup_enable),
  .charger_dm_pullup_enable(charger_dm_pullup_enable),
  .xcvr_select(xcvr_select), .term_select(term_select),
  .op_mode(op_mode), .suspend_n(suspend_n));

// ### tb/ucd_link_model.sv
// Link controller model facing the device data bus.
`timescale 1ns/1ps
module ucd_link_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Mode wanted by the test
  input wire ucd_pkg::ucd_mode_e mode_req,
  // Device data bus
  input wire logic [7:0] ulpi_dout,
  input wire logic ulpi_doe,
  input wire logic rxcmd_valid,
  // Towards device and test
  output ucd_pkg::ucd_mode_e ulpi_mode,
  output logic [7:0] last_rxcmd,
  output logic [1:0] line_level,
  output logic int_seen
);
  import ucd_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ulpi_mode <= UCD_MODE_SYNC;
      last_rxcmd <= 8'h00;
    end else begin
      ulpi_mode <= mode_req;
      if (rxcmd_valid && ulpi_doe) begin
        last_rxcmd <= ulpi_dout;
      end
    end
  end
  assign line_level = ulpi_dout[1:0];
  assign int_seen = ulpi_dout[3];
endmodule

// ### tb/ucd_top_bench.sv
// Self-checking bench for the charger detection register block.
`timescale 1ns/1ps
module ucd_top_bench;
  import ucd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, doe, rxv, irq, dp_pu, dm_pu, id_pu, term, susp;
  logic [1:0] xcvr, opm, lvl;
  logic [7:0] dout, lrx;
  logic int_seen;
  ucd_pins_s pins;
  ucd_mode_e mode_req, mode;
  int failures, comparisons;
  ucd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins),
    .ulpi_mode(mode), .ulpi_dout(dout), .ulpi_doe(doe), .rxcmd_valid(rxv),
    .charger_dp_pullup_enable(dp_pu), .charger_dm_pullup_enable(dm_pu),
    .id_pin_pullup_enable(id_pu), .xcvr_select(xcvr), .term_select(term),
    .op_mode(opm), .suspend_n(susp), .irq(irq));
  ucd_link_model link_u (.pclk(pclk), .presetn(presetn),
    .mode_req(mode_req), .ulpi_dout(dout), .ulpi_doe(doe),
    .rxcmd_valid(rxv), .ulpi_mode(mode), .last_rxcmd(lrx),
    .line_level(lvl), .int_seen(int_seen));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================================
  // Tasks
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [11:0] a,
                      input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(n, rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic stop_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pins = '0;
    mode_req = UCD_MODE_SYNC;
    failures = 0;
    comparisons = 0;
    cyc(20);
    presetn <= 1'b1;
    rchk("func", 12'h010, 32'h41);
    rchk("io", 12'h0e8, 32'h04);
    xfer(1'b0, 12'h200, 32'h0);
    check("slverr", err, 1);
    check("unmapped", rd, 0);
    xfer(1'b1, 12'h108, 32'hf);
    xfer(1'b1, 12'h10c, 32'h0);
    pins.id_grounded <= 1'b1;
    pins.id_resistance <= 3'h5;
    cyc(8);
    xfer(1'b1, 12'h104, 32'h1);
    cyc(2);
    check("idpu", id_pu, 1);
    xfer(1'b1, 12'h104, 32'h3);
    cyc(UCD_RID_CONV_CYC - 10);
    xfer(1'b0, 12'h100, 32'h0);
    check("early", rd[2], 0);
    cyc(12);
    rchk("status", 12'h100, {24'h0, 2'b00, 3'h5, 3'b110});
    check("masked", irq, 0);
    xfer(1'b1, 12'h10c, 32'h4);
    mode_req <= UCD_MODE_LOWPOWER;
    cyc(6);
    check("int", int_seen, 1);
    check("irq", irq, 1);
    mode_req <= UCD_MODE_SYNC;
    cyc(2);
    rchk("cause", 12'h108, 32'h6);
    xfer(1'b1, 12'h108, 32'h4);
    cyc(3);
    check("clear", irq, 0);
    for (int i = 0; i < 2; i++) begin
      pins.dp_level <= i[0];
      pins.dm_level <= i[0];
      mode_req <= UCD_MODE_LOWPOWER;
      cyc(8);
      check("line", lvl, {2{i[0]}});
      mode_req <= UCD_MODE_SYNC;
      cyc(8);
      rchk("debug", 12'h054, {30'h0, {2{i[0]}}});
    end
    pins.session_valid <= 1'b1;
    cyc(8);
    check("rxcmd", lrx, 8'h4b);
    xfer(1'b1, 12'h010, 32'h49);
    cyc(2);
    check("fs", {susp, opm, term, xcvr}, 6'b101001);
    xfer(1'b1, 12'h0e8, 32'h14);
    cyc(2);
    check("dp", {dm_pu, dp_pu}, 2'b01);
    xfer(1'b1, 12'h0e8, 32'h34);
    cyc(2);
    check("dm", {dm_pu, dp_pu}, 2'b11);
    xfer(1'b1, 12'h0e8, 32'h04);
    xfer(1'b1, 12'h010, 32'h41);
    cyc(2);
    check("off", {dm_pu, dp_pu}, 2'b00);
    check("restore", {susp, opm, term, xcvr}, 6'b100001);
    mode_req <= UCD_MODE_UART;
    cyc(4);
    check("uart", {dm_pu, dp_pu}, 2'b11);
    stop_test;
  end
  initial begin
    #400000;
    failures++;
    stop_test;
  end
endmodule
